// *** design/tx_ilas_config_regs.sv ***
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - adjust request bit 31, self-clears after MF2
// - direction bit 30, 1 delays, self-clears
// - four step bits 19:16, self-clear after MF2
// - two reserved octets, writable, reset zero
// - lane ids 0-3, five bits per byte
// - lane ids 4-7, same byte placement
// - checksums lanes 0-3, one per byte
// - register contents sent in ilas data, adjust fields in subclass 2 only
module tx_ilas_config_regs
    import ilas_cfg_pkg::*;
#(
    parameter int          LANES       = 8,
    parameter logic [31:0] RST_LANE_LO_P = RST_LANE_LO,
    parameter logic [31:0] RST_LANE_HI_P = RST_LANE_HI,
    parameter logic [31:0] RST_CHK_LO_P  = RST_CHKSUM_LO
)
(
    // clocking
    input  wire logic                    clock,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    // avalon-mm slave
    input  wire logic [7:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    // data link layer events
    input  wire logic                    ilas_start,
    input  wire logic                    mf_sent,
    // ilas content to data link layer
    output logic                         ilas_adj_request,
    output logic                         ilas_adj_delay,
    output logic [STEP_W-1:0]            ilas_adj_steps,
    output logic [OCTET_W-1:0]           ilas_reserved_octet_one,
    output logic [OCTET_W-1:0]           ilas_reserved_octet_two,
    output logic [LANES*LANE_ID_W-1:0]   lane_identifier,
    output logic [31:0]                  lane_config_checksum_low
);

    logic [31:0]           phase_adj_reg;
    logic [31:0]           lane_lo_reg;
    logic [31:0]           lane_hi_reg;
    logic [31:0]           chk_lo_reg;
    logic [SUBCLASS_W-1:0] subclass_reg;
    logic                  adj_done_reg;
    logic                  ack_reg;
    logic                  clear_pulse;
    logic                  wr_stb;
    logic                  rd_stb;
    logic [31:0]           be_mask;
    logic [31:0]           rd_next;
    logic [31:0]           lane_lo_shown;
    logic [31:0]           lane_hi_shown;
    logic                  sc2;

    // ==========================================================
    // bus handshake: one wait cycle, then ack
    assign wr_stb = avs_write && !ack_reg;
    assign rd_stb = avs_read && !ack_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    // waitrequest high until the ack cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
        end
    end

    // byte enables widened to a bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    end

    // ==========================================================
    // adjust-done event from the multiframe counter
    ilas_adj_clear u_adj_clear (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .ilas_start  (ilas_start),
        .mf_sent     (mf_sent),
        .clear_pulse (clear_pulse)
    );

    // ==========================================================
    // phase adjust and reserved octets
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_adj_reg <= RST_PHASE_ADJ;
        end else if (clk_en) begin
            if (wr_stb && avs_address == OFS_PHASE_ADJ) begin
                phase_adj_reg <= (phase_adj_reg & ~(be_mask & MSK_PHASE_ADJ))
                               | (avs_writedata & be_mask & MSK_PHASE_ADJ);
            end else if (clear_pulse) begin
                phase_adj_reg[POS_ADJ_REQ] <= 1'b0;
                phase_adj_reg[POS_ADJ_DIR] <= 1'b0;
                phase_adj_reg[POS_STEP_LO +: STEP_W] <= '0;
            end
        end
    end

    // done flag: the self-clear event wins over a phase adjust write in the same cycle; in phase_adj_reg the write wins
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            adj_done_reg <= 1'b0;
        end else if (clk_en) begin
            if (clear_pulse) begin
                adj_done_reg <= 1'b1;
            end else if (wr_stb && avs_address == OFS_PHASE_ADJ) begin
                adj_done_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // lane identifiers and checksums
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lane_lo_reg <= RST_LANE_LO_P & MSK_LANE_ID;
        end else if (clk_en && wr_stb && avs_address == OFS_LANE_ID_LO) begin
            lane_lo_reg <= (lane_lo_reg & ~(be_mask & MSK_LANE_ID))
                         | (avs_writedata & be_mask & MSK_LANE_ID);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lane_hi_reg <= RST_LANE_HI_P & MSK_LANE_ID;
        end else if (clk_en && wr_stb && avs_address == OFS_LANE_ID_HI) begin
            lane_hi_reg <= (lane_hi_reg & ~(be_mask & MSK_LANE_ID))
                         | (avs_writedata & be_mask & MSK_LANE_ID);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chk_lo_reg <= RST_CHK_LO_P;
        end else if (clk_en && wr_stb && avs_address == OFS_CHKSUM_LO) begin
            chk_lo_reg <= (chk_lo_reg & ~be_mask) | (avs_writedata & be_mask);
        end
    end

    // link subclass setting
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            subclass_reg <= RST_SUBCLASS;
        end else if (clk_en && wr_stb && avs_address == OFS_LINK_CTRL
                     && avs_byteenable[0]) begin
            subclass_reg <= avs_writedata[POS_SUBCLASS +: SUBCLASS_W];
        end
    end

    // ==========================================================
    // read mux
    assign lane_lo_shown = lane_lo_reg & MSK_LANE_ID;
    assign lane_hi_shown = lane_hi_reg & MSK_LANE_ID;

    always_comb begin
        rd_next = UNMAPPED_DATA;
        unique case (avs_address)
            OFS_PHASE_ADJ:  rd_next = phase_adj_reg & MSK_PHASE_ADJ;
            OFS_LANE_ID_LO: rd_next = lane_lo_shown;
            OFS_LANE_ID_HI: rd_next = lane_hi_shown;
            OFS_CHKSUM_LO:  rd_next = chk_lo_reg;
            OFS_LINK_CTRL:  rd_next = {29'h0, subclass_reg};
            OFS_STATUS:     rd_next = {31'h0, adj_done_reg};
            default:        rd_next = UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en && rd_stb) begin
            avs_readdata <= rd_next;
        end
    end

    // ==========================================================
    // ilas content outputs
    assign sc2 = (subclass_reg == SUBCLASS_2);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ilas_adj_request <= 1'b0;
            ilas_adj_delay   <= 1'b0;
            ilas_adj_steps   <= '0;
        end else if (clk_en) begin
            ilas_adj_request <= sc2 && phase_adj_reg[POS_ADJ_REQ];
            ilas_adj_delay   <= sc2 && phase_adj_reg[POS_ADJ_DIR];
            ilas_adj_steps   <= sc2 ? phase_adj_reg[POS_STEP_LO +: STEP_W]
                                    : '0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ilas_reserved_octet_one  <= '0;
            ilas_reserved_octet_two  <= '0;
            lane_config_checksum_low <= '0;
        end else if (clk_en) begin
            ilas_reserved_octet_one  <= phase_adj_reg[POS_OCT_ONE +: OCTET_W];
            ilas_reserved_octet_two  <= phase_adj_reg[POS_OCT_TWO +: OCTET_W];
            lane_config_checksum_low <= chk_lo_reg;
        end
    end

    // per-lane identifier unpack
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                lane_identifier[g*LANE_ID_W +: LANE_ID_W] <= '0;
            end else if (clk_en) begin
                lane_identifier[g*LANE_ID_W +: LANE_ID_W] <=
                    (g < LANES_PER_WD)
                    ? lane_lo_shown[(g % LANES_PER_WD)*BYTE_W +: LANE_ID_W]
                    : lane_hi_shown[(g % LANES_PER_WD)*BYTE_W +: LANE_ID_W];
            end
        end
    end

endmodule : tx_ilas_config_regs

// *** inc/ilas_cfg_pkg.sv ***
package ilas_cfg_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_PHASE_ADJ  = 8'h9C;
    localparam logic [7:0] OFS_LANE_ID_LO = 8'hA0;
    localparam logic [7:0] OFS_LANE_ID_HI = 8'hA4;
    localparam logic [7:0] OFS_CHKSUM_LO  = 8'hB0;
    localparam logic [7:0] OFS_LINK_CTRL  = 8'hB4;
    localparam logic [7:0] OFS_STATUS     = 8'hB8;

    // ==========================================================
    // phase adjust word fields
    localparam int POS_ADJ_REQ   = 31;
    localparam int POS_ADJ_DIR   = 30;
    localparam int POS_STEP_LO   = 16;
    localparam int STEP_W        = 4;
    localparam int POS_OCT_TWO   = 8;
    localparam int POS_OCT_ONE   = 0;
    localparam int OCTET_W       = 8;

    // lane id word: one lane per byte, five bits used
    localparam int LANE_ID_W     = 5;
    localparam int LANES_PER_WD  = 4;
    localparam int BYTE_W        = 8;

    // link control word fields
    localparam int POS_SUBCLASS  = 0;
    localparam int SUBCLASS_W    = 3;
    localparam logic [2:0] SUBCLASS_2 = 3'h2;

    // ==========================================================
    // reset values
    localparam logic [31:0] RST_PHASE_ADJ = 32'h0000_0000;
    localparam logic [31:0] RST_LANE_LO   = 32'h0302_0100;
    localparam logic [31:0] RST_LANE_HI   = 32'h0706_0504;
    localparam logic [31:0] RST_CHKSUM_LO = 32'h0000_0000;
    localparam logic [2:0]  RST_SUBCLASS  = 3'h1;

    // field masks of writable bits
    localparam logic [31:0] MSK_PHASE_ADJ = 32'hC00F_FFFF;
    localparam logic [31:0] MSK_LANE_ID   = 32'h1F1F_1F1F;

    // answer for unmapped reads
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage : ilas_cfg_pkg

// *** design/ilas_adj_clear.sv ***
`timescale 1ns/1ps
// counts ilas multiframes sent, pulses once after the second
module ilas_adj_clear
    import ilas_cfg_pkg::*;
(
    // clocking
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // link layer events
    input  wire logic ilas_start,
    input  wire logic mf_sent,
    // result
    output logic      clear_pulse
);

    logic [1:0] mf_cnt_reg;

    // ==========================================================
    // multiframe counter, restarted with each ilas
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mf_cnt_reg <= 2'h0;
        end else if (clk_en) begin
            if (ilas_start) begin
                mf_cnt_reg <= 2'h0;
            end else if (mf_sent && mf_cnt_reg != 2'h2) begin
                mf_cnt_reg <= mf_cnt_reg + 2'h1;
            end
        end
    end

    // one pulse as the second multiframe completes
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clear_pulse <= 1'b0;
        end else if (clk_en) begin
            clear_pulse <= !ilas_start && mf_sent && mf_cnt_reg == 2'h1;
        end
    end

endmodule : ilas_adj_clear

// *** sim/tx_ilas_config_regs_checker.sv ***
`timescale 1ns/1ps
// ==========================================
// port checker of the ilas register bank
module tx_ilas_config_regs_checker
    import ilas_cfg_pkg::*;
#(parameter int LANES = 8)
(
    // clocking and bus
    input wire logic clock, sys_rst, clk_en, avs_read, avs_write,
    input wire logic [7:0]  avs_address,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [3:0]  avs_byteenable,
    // waitrequest, link events and ilas content
    input wire logic avs_waitrequest, ilas_start, mf_sent,
    input wire logic ilas_adj_request, ilas_adj_delay,
    input wire logic [STEP_W-1:0]  ilas_adj_steps,
    input wire logic [OCTET_W-1:0] ilas_reserved_octet_one,
    input wire logic [OCTET_W-1:0] ilas_reserved_octet_two,
    input wire logic [LANES*LANE_ID_W-1:0] lane_identifier,
    input wire logic [31:0] lane_config_checksum_low
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [1:0]  mf_cnt_reg;
    logic [2:0]  subclass_reg;
    logic        wr_ack;
    logic [19:0] wd_ids;
    // acknowledged full-word write, lane ids packed
    assign wr_ack = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
    assign wd_ids = {avs_writedata[28:24], avs_writedata[20:16],
                     avs_writedata[12:8], avs_writedata[4:0]};
    // multiframes since ilas start
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) mf_cnt_reg <= 2'h0;
        else if (ilas_start) mf_cnt_reg <= 2'h0;
        else if (mf_sent && !mf_cnt_reg[1])
            mf_cnt_reg <= mf_cnt_reg + 2'h1;
    end
    // shadow of the subclass field
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) subclass_reg <= RST_SUBCLASS;
        else if (wr_ack && avs_address == OFS_LINK_CTRL)
            subclass_reg <= avs_writedata[2:0];
    end
    sequence s_second_mf;
        mf_sent && mf_cnt_reg == 2'h1 && !ilas_start;
    endsequence
    a_req_self_clear: assert property (s_second_mf |-> ##[1:4]
        !ilas_adj_request) else $error("request not cleared");
    a_dir_self_clear: assert property (s_second_mf |-> ##[1:4]
        !ilas_adj_delay) else $error("direction not cleared");
    a_steps_self_clear: assert property (s_second_mf |-> ##[1:4]
        ilas_adj_steps == 4'h0) else $error("steps not cleared");
    a_adjust_gated: assert property (subclass_reg != SUBCLASS_2
        && $past(subclass_reg) != SUBCLASS_2 |-> !ilas_adj_request
        && !ilas_adj_delay && ilas_adj_steps == 4'h0)
        else $error("adjust shown outside subclass two");
    a_octets_follow: assert property (wr_ack
        && avs_address == OFS_PHASE_ADJ |-> ##2 {ilas_reserved_octet_two,
        ilas_reserved_octet_one} == $past(avs_writedata[15:0], 2))
        else $error("octets do not follow write");
    a_lane_low_follow: assert property (wr_ack
        && avs_address == OFS_LANE_ID_LO |-> ##2
        lane_identifier[19:0] == $past(wd_ids, 2))
        else $error("low lane ids do not follow write");
    a_lane_high_follow: assert property (wr_ack
        && avs_address == OFS_LANE_ID_HI |-> ##2
        lane_identifier[39:20] == $past(wd_ids, 2))
        else $error("high lane ids do not follow write");
    a_chk_follow: assert property (wr_ack
        && avs_address == OFS_CHKSUM_LO |-> ##2
        lane_config_checksum_low == $past(avs_writedata, 2))
        else $error("checksums do not follow write");
    // main scenarios reached
    c_second_mf: cover property (s_second_mf);
    c_phase_write: cover property (wr_ack && avs_address == OFS_PHASE_ADJ);
    c_unmapped: cover property (avs_read && !avs_waitrequest
        && avs_address == 8'h00);
endmodule : tx_ilas_config_regs_checker
bind tx_ilas_config_regs tx_ilas_config_regs_checker #(.LANES(LANES)) chk_i (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .avs_read(avs_read),
    .avs_write(avs_write), .avs_address(avs_address),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .ilas_start(ilas_start), .mf_sent(mf_sent),
    .ilas_adj_request(ilas_adj_request), .ilas_adj_delay(ilas_adj_delay),
    .ilas_adj_steps(ilas_adj_steps),
    .ilas_reserved_octet_one(ilas_reserved_octet_one),
    .ilas_reserved_octet_two(ilas_reserved_octet_two),
    .lane_identifier(lane_identifier),
    .lane_config_checksum_low(lane_config_checksum_low));

// *** sim/ilas_link_model.sv ***
`timescale 1ns/1ps
// ==========================================
// link layer stand-in: one ilas per go
module ilas_link_model (
    // control from bench
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       go,
    input  wire logic [3:0] frames,
    input  wire logic [3:0] gap,
    // events to the register bank
    output logic            ilas_start,
    output logic            mf_sent,
    output logic            idle
);
    // start pulse, then gap-spaced multiframe pulses
    initial begin
        ilas_start = 1'b0;
        mf_sent = 1'b0;
        idle = 1'b1;
        forever begin
            @(posedge clock);
            if (go && !sys_rst) begin
                idle <= 1'b0;
                ilas_start <= 1'b1;
                @(posedge clock) ilas_start <= 1'b0;
                repeat (frames) begin
                    repeat (gap) @(posedge clock);
                    mf_sent <= 1'b1;
                    @(posedge clock) mf_sent <= 1'b0;
                end
                idle <= 1'b1;
            end
        end
    end
endmodule : ilas_link_model

// *** sim/test_tx_ilas_config_regs.sv ***
`timescale 1ns/1ps
// ==========================================
// bench of the ilas register bank
module test_tx_ilas_config_regs;
    import ilas_cfg_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd, chk_low;
    logic        avs_waitrequest, ilas_start, mf_sent, adj_req, adj_dly;
    logic [3:0]  adj_steps, gap = 4'h1, frames = 4'h2;
    logic [7:0]  oct_one, oct_two;
    logic [39:0] lane_ids;
    logic        go = 1'b0, idle;
    int          fail_count = 0, cmp_count = 0, cycles = 0;
    // clock and instances
    always #5 clock = ~clock;
    tx_ilas_config_regs uut (.clock(clock), .sys_rst(sys_rst),
        .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ilas_start(ilas_start),
        .mf_sent(mf_sent), .ilas_adj_request(adj_req),
        .ilas_adj_delay(adj_dly), .ilas_adj_steps(adj_steps),
        .ilas_reserved_octet_one(oct_one), .ilas_reserved_octet_two(oct_two),
        .lane_identifier(lane_ids), .lane_config_checksum_low(chk_low));
    ilas_link_model link (.clock(clock), .sys_rst(sys_rst), .go(go),
        .frames(frames), .gap(gap), .ilas_start(ilas_start),
        .mf_sent(mf_sent), .idle(idle));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one avalon transfer, held until waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rdc
    task automatic run_link(input logic [3:0] n, input logic [3:0] g);
        frames <= n;
        gap <= g;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        while (idle !== 1'b1) @(posedge clock);
        repeat (5) @(posedge clock);
    endtask : run_link
    task automatic t_reset;
        rdc(OFS_PHASE_ADJ, 32'h0000_0000);
        rdc(OFS_LANE_ID_LO, RST_LANE_LO);
        rdc(OFS_LANE_ID_HI, RST_LANE_HI);
        rdc(OFS_CHKSUM_LO, RST_CHKSUM_LO);
        rdc(8'h00, UNMAPPED_DATA);
        check(lane_ids, 40'h39_8A41_8820);
        $display("reset values done");
    endtask : t_reset
    task automatic t_lanes;
        bus(1'b1, OFS_LANE_ID_LO, 32'hFFFF_FFFF);
        bus(1'b1, OFS_LANE_ID_HI, 32'h1A0B_1C0D);
        rdc(OFS_LANE_ID_LO, 32'h1F1F_1F1F);
        rdc(OFS_LANE_ID_HI, 32'h1A0B_1C0D);
        check(lane_ids, {5'h1A, 5'h0B, 5'h1C, 5'h0D, 20'hF_FFFF});
        $display("lane ids done");
    endtask : t_lanes
    task automatic t_chk;
        logic [7:0] sum;
        // lane 0 sum of three parameters, wrapped
        sum = 8'h21 + 8'hF0 + 8'h33;
        bus(1'b1, OFS_CHKSUM_LO, {24'hA5_5A0F, sum});
        rdc(OFS_CHKSUM_LO, 32'hA55A_0F44);
        check(chk_low, 32'hA55A_0F44);
        $display("checksums done");
    endtask : t_chk
    task automatic t_adjust;
        bus(1'b1, OFS_PHASE_ADJ, 32'hFFFF_5AA5);
        rdc(OFS_PHASE_ADJ, 32'hC00F_5AA5);
        check({oct_two, oct_one}, 16'h5AA5);
        check({adj_req, adj_dly, adj_steps}, 6'h00);
        bus(1'b1, OFS_LINK_CTRL, 32'h0000_0002);
        rdc(OFS_LINK_CTRL, 32'h0000_0002);
        rdc(OFS_STATUS, 32'h0000_0000);
        repeat (2) @(posedge clock);
        check({adj_req, adj_dly, adj_steps}, 6'h3F);
        run_link(4'h1, 4'h6);
        check({adj_req, adj_dly, adj_steps}, 6'h3F);
        run_link(4'h2, 4'h6);
        check({adj_req, adj_dly, adj_steps}, 6'h00);
        rdc(OFS_PHASE_ADJ, 32'h0000_5AA5);
        bus(1'b1, OFS_PHASE_ADJ, 32'h8005_0000);
        repeat (2) @(posedge clock);
        check({adj_req, adj_dly, adj_steps}, 6'h25);
        run_link(4'h2, 4'h1);
        rdc(OFS_PHASE_ADJ, 32'h0000_0000);
        rdc(OFS_STATUS, 32'h0000_0001);
        bus(1'b1, OFS_PHASE_ADJ, 32'hC003_0000);
        rdc(OFS_STATUS, 32'h0000_0000);
        bus(1'b1, OFS_LINK_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clock);
        check({adj_req, adj_dly, adj_steps}, 6'h00);
        $display("phase adjust done");
    endtask : t_adjust
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // cycle ceiling against hangs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            final_report();
        end
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_lanes();
        t_chk();
        t_adjust();
        final_report();
    end
endmodule : test_tx_ilas_config_regs
